// ### hdl/rtca_alarm_sqw.sv
// Alarm compare registers and programmable square-wave output of the clock.
`timescale 1ns/100ps
// Behaviour
// - Minute bit 7 disables minute matching; reset sets it to 1.
// - Hour alarm holds BCD 00 to 23 in bits 5:0; bit 6 unused.
// - Hour bit 7 disables hour matching; reset value 1.
// - Date alarm holds BCD 01 to 31 in bits 5:0; bit 6 unused.
// - Date bit 7 disables date matching; reset value 1.
// - Weekday alarm holds 0 to 6 in bits 2:0; bits 6:3 unused.
// - Weekday bit 7 disables weekday matching; reset value 1.
// - Square-wave enable at 0 stops the pin and holds it low.
// - Square-wave enable is bit 7; writing 1 runs it; resets to 1.
// - Rate select 00/01/10/11 gives 32.768 kHz, 1024 Hz, 32 Hz, 1 Hz.
// - Pin toggles only while enable bit and outside gate pin both allow.
// - After reset, with gate high, the pin runs at 32.768 kHz.
module rtca_alarm_sqw
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [rtca_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic [6:0] cur_minute_i,
  input wire logic [5:0] cur_hour_i,
  input wire logic [5:0] cur_date_i,
  input wire logic [2:0] cur_weekday_i,
  input wire logic timebase_i,
  input wire logic square_wave_gate_pin_i,
  output logic square_wave_pin_o,
  output logic alarm_match_o
);
  import rtca_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0] minute_alarm_reg;
  logic [7:0] hour_alarm_reg;
  logic [7:0] date_alarm_reg;
  logic [7:0] weekday_alarm_reg;
  logic [7:0] square_wave_control_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic tb_meta_reg;
  logic tb_sync_reg;
  logic tb_prev_reg;
  logic gate_meta_reg;
  logic gate_sync_reg;
  logic sqw_pin_reg;
  logic sqw_pin_next;
  logic match_reg;
  logic match_next;
  logic minute_match_disable;
  logic hour_match_disable;
  logic date_match_disable;
  logic weekday_match_disable;
  logic square_wave_output_on;
  rtca_rate_t square_wave_rate_select;
  logic wr_minute;
  logic wr_hour;
  logic wr_date;
  logic wr_weekday;
  logic wr_sqw;

  rtca_div_if div_bus ();

  // ==========================================================================
  // Register writes
  // ==========================================================================
  // Address decode for the write strobes; other addresses belong to other blocks.
  assign wr_minute = reg_wr_i && (reg_addr_i == OFF_MINUTE_ALARM);
  assign wr_hour = reg_wr_i && (reg_addr_i == OFF_HOUR_ALARM);
  assign wr_date = reg_wr_i && (reg_addr_i == OFF_DATE_ALARM);
  assign wr_weekday = reg_wr_i && (reg_addr_i == OFF_WEEKDAY_ALARM);
  assign wr_sqw = reg_wr_i && (reg_addr_i == OFF_SQUARE_WAVE);

  // Minute alarm value and its match disable; the value is stored as written.
  // minute alarm store
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      minute_alarm_reg <= MINUTE_ALARM_RST;
    end
    else if (wr_minute)
    begin
      minute_alarm_reg <= reg_wdata_i & MINUTE_WR_MASK;
    end
  end

  // Hour alarm; the unused bit is not stored so it always reads zero.
  // hour alarm store
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      hour_alarm_reg <= HOUR_ALARM_RST;
    end
    else if (wr_hour)
    begin
      hour_alarm_reg <= reg_wdata_i & HOUR_WR_MASK;
    end
  end

  // Date alarm; out-of-range BCD is kept, it simply never matches.
  // date alarm store
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      date_alarm_reg <= DATE_ALARM_RST;
    end
    else if (wr_date)
    begin
      date_alarm_reg <= reg_wdata_i & DATE_WR_MASK;
    end
  end

  // Weekday alarm keeps three value bits plus the disable bit.
  // weekday alarm store
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      weekday_alarm_reg <= WEEKDAY_ALARM_RST;
    end
    else if (wr_weekday)
    begin
      weekday_alarm_reg <= reg_wdata_i & WEEKDAY_WR_MASK;
    end
  end

  // Square-wave control: enable in bit 7, rate in bits 1:0, reset runs 32 kHz.
  // square-wave control store
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      square_wave_control_reg <= SQUARE_WAVE_RST;
    end
    else if (wr_sqw)
    begin
      square_wave_control_reg <= reg_wdata_i & SQW_WR_MASK;
    end
  end

  // Named fields of the stored registers.
  assign minute_match_disable = minute_alarm_reg[MATCH_DIS_BIT];
  assign hour_match_disable = hour_alarm_reg[MATCH_DIS_BIT];
  assign date_match_disable = date_alarm_reg[MATCH_DIS_BIT];
  assign weekday_match_disable = weekday_alarm_reg[MATCH_DIS_BIT];
  assign square_wave_output_on = square_wave_control_reg[SQW_ON_BIT];
  assign square_wave_rate_select = rtca_rate_t'(square_wave_control_reg[1:0]);

  // ==========================================================================
  // Register reads
  // ==========================================================================
  // Read mux; an unmapped address answers with zero rather than stale data.
  always_comb
  begin
    unique case (reg_addr_i)
      OFF_MINUTE_ALARM: rdata_next = minute_alarm_reg;
      OFF_HOUR_ALARM: rdata_next = hour_alarm_reg;
      OFF_DATE_ALARM: rdata_next = date_alarm_reg;
      OFF_WEEKDAY_ALARM: rdata_next = weekday_alarm_reg;
      OFF_SQUARE_WAVE: rdata_next = square_wave_control_reg;
      default: rdata_next = UNMAPPED_READ;
    endcase
  end

  // Read data is captured on the clock edge that samples the strobe and held until the next.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg <= UNMAPPED_READ;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= reg_rd_i;
      if (reg_rd_i)
      begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Both pins are asynchronous to clk_i; only the second stage, and for the timebase a third edge-detect stage, is ever used.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      tb_meta_reg <= 1'b0;
      tb_sync_reg <= 1'b0;
      tb_prev_reg <= 1'b0;
      gate_meta_reg <= 1'b0;
      gate_sync_reg <= 1'b0;
    end
    else
    begin
      tb_meta_reg <= timebase_i;
      tb_sync_reg <= tb_meta_reg;
      tb_prev_reg <= tb_sync_reg;
      gate_meta_reg <= square_wave_gate_pin_i;
      gate_sync_reg <= gate_meta_reg;
    end
  end

  // ==========================================================================
  // Square-wave generation
  // ==========================================================================
  // One tick per rising timebase edge drives the divider.
  assign div_bus.tick = tb_sync_reg && !tb_prev_reg;

  rtca_divider u_divider
  (
    .clk_i (clk_i),
    .rst_n_i (rst_n_i),
    .div (div_bus.div)
  );

  // Rate selection; the full rate follows the timebase itself, lower rates a tap.
  // rate select
  always_comb
  begin
    sqw_pin_next = 1'b0;
    if (square_wave_output_on && gate_sync_reg)
    begin
      unique case (square_wave_rate_select)
        RTCA_RATE_32K: sqw_pin_next = tb_sync_reg;
        RTCA_RATE_1K: sqw_pin_next = div_bus.count[TAP_1K];
        RTCA_RATE_32: sqw_pin_next = div_bus.count[TAP_32];
        RTCA_RATE_1: sqw_pin_next = div_bus.count[TAP_1];
      endcase
    end
  end

  // Registered pin; the output lags the timebase by three clk_i cycles at the full rate, four at the divided rates.
  // pin register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sqw_pin_reg <= 1'b0;
    end
    else
    begin
      sqw_pin_reg <= sqw_pin_next;
    end
  end

  // ==========================================================================
  // Alarm compare
  // ==========================================================================
  // A disabled field counts as matched, but at least one must be enabled.
  // alarm compare
  assign match_next =
    (minute_match_disable || (cur_minute_i == minute_alarm_reg[6:0])) &&
    (hour_match_disable || (cur_hour_i == hour_alarm_reg[5:0])) &&
    (date_match_disable || (cur_date_i == date_alarm_reg[5:0])) &&
    (weekday_match_disable || (cur_weekday_i == weekday_alarm_reg[2:0])) &&
    !(minute_match_disable && hour_match_disable &&
      date_match_disable && weekday_match_disable);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      match_reg <= 1'b0;
    end
    else
    begin
      match_reg <= match_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata_o = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;
  assign square_wave_pin_o = sqw_pin_reg;
  assign alarm_match_o = match_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_sqw_running(rtca_rate_t rate);
    square_wave_output_on && gate_sync_reg && (square_wave_rate_select == rate);
  endsequence

  sequence s_only_minute_hits;
    !minute_match_disable && hour_match_disable && date_match_disable &&
    weekday_match_disable && (cur_minute_i == minute_alarm_reg[6:0]);
  endsequence

  AST_MINUTE_WRITE: assert property (
    wr_minute |=> minute_alarm_reg == $past(reg_wdata_i))
    else $error("Minute alarm did not store the written byte.");

  AST_ALARM_RESET_DISABLED: assert property (
    $rose(rst_n_i) |-> minute_match_disable && hour_match_disable &&
      date_match_disable && weekday_match_disable)
    else $error("An alarm field was enabled right after reset.");

  AST_HOUR_WRITE: assert property (
    wr_hour |=> hour_alarm_reg == {$past(reg_wdata_i[7]), 1'b0, $past(reg_wdata_i[5:0])})
    else $error("Hour alarm write stored the wrong bits.");

  AST_DATE_WRITE: assert property (
    wr_date |=> date_alarm_reg == {$past(reg_wdata_i[7]), 1'b0, $past(reg_wdata_i[5:0])})
    else $error("Date alarm write stored the wrong bits.");

  AST_WEEKDAY_READ: assert property (
    (reg_rd_i && reg_addr_i == OFF_WEEKDAY_ALARM) |=> reg_rvalid_o &&
      reg_rdata_o[6:3] == 4'h0 && reg_rdata_o[7] == $past(weekday_match_disable))
    else $error("Weekday alarm read showed unused bits or wrong disable.");

  AST_PIN_LOW_WHEN_OFF: assert property (
    (!square_wave_output_on || !gate_sync_reg) |=> !square_wave_pin_o)
    else $error("Square-wave pin high while stopped.");

  AST_SQW_RESET: assert property (
    $rose(rst_n_i) |-> square_wave_output_on &&
      square_wave_rate_select == RTCA_RATE_32K)
    else $error("Square-wave control not at its reset setting.");

  AST_FULL_RATE_FOLLOWS: assert property (
    s_sqw_running(RTCA_RATE_32K) |=> square_wave_pin_o == $past(tb_sync_reg))
    else $error("Full-rate output does not follow the timebase.");

  AST_RATE_1K_TAP: assert property (
    s_sqw_running(RTCA_RATE_1K) |=> square_wave_pin_o == $past(div_bus.count[4]))
    else $error("1024 Hz output is not the fifth divider bit.");

  AST_RATE_32_TAP: assert property (
    s_sqw_running(RTCA_RATE_32) |=> square_wave_pin_o == $past(div_bus.count[9]))
    else $error("32 Hz output is not the tenth divider bit.");

  AST_RATE_1HZ_TAP: assert property (
    s_sqw_running(RTCA_RATE_1) |=> square_wave_pin_o == $past(div_bus.count[14]))
    else $error("1 Hz output is not the top divider bit.");

  AST_MATCH_MINUTE_ONLY: assert property (
    s_only_minute_hits |=> alarm_match_o)
    else $error("Minute-only alarm failed to match.");

  AST_NO_MATCH_ALL_OFF: assert property (
    (minute_match_disable && hour_match_disable && date_match_disable &&
      weekday_match_disable) |=> !alarm_match_o)
    else $error("Alarm matched with every field disabled.");

endmodule : rtca_alarm_sqw

// ### hdl/rtca_pkg.sv
// Package of constants and types for the alarm compare and square-wave block.
package rtca_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_MINUTE_ALARM = 4'h9;
  localparam logic [3:0] OFF_HOUR_ALARM = 4'hA;
  localparam logic [3:0] OFF_DATE_ALARM = 4'hB;
  localparam logic [3:0] OFF_WEEKDAY_ALARM = 4'hC;
  localparam logic [3:0] OFF_SQUARE_WAVE = 4'hD;

  // ==========================================================================
  // Field layout
  // ==========================================================================
  localparam int MATCH_DIS_BIT = 7;
  localparam int SQW_ON_BIT = 7;
  localparam logic [7:0] MINUTE_WR_MASK = 8'hFF;
  localparam logic [7:0] HOUR_WR_MASK = 8'hBF;
  localparam logic [7:0] DATE_WR_MASK = 8'hBF;
  localparam logic [7:0] WEEKDAY_WR_MASK = 8'h87;
  localparam logic [7:0] SQW_WR_MASK = 8'h83;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] MINUTE_ALARM_RST = 8'h80;
  localparam logic [7:0] HOUR_ALARM_RST = 8'h80;
  localparam logic [7:0] DATE_ALARM_RST = 8'h80;
  localparam logic [7:0] WEEKDAY_ALARM_RST = 8'h80;
  localparam logic [7:0] SQUARE_WAVE_RST = 8'h80;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================================
  // Rates and divider taps
  // ==========================================================================
  typedef enum logic [1:0] {
    RTCA_RATE_32K = 2'b00,
    RTCA_RATE_1K = 2'b01,
    RTCA_RATE_32 = 2'b10,
    RTCA_RATE_1 = 2'b11
  } rtca_rate_t;

  localparam int CLK_HZ = 20000000;
  localparam int TIMEBASE_HZ = 32768;
  localparam int RATE_1K_HZ = 1024;
  localparam int RATE_32_HZ = 32;
  localparam int RATE_1_HZ = 1;
  localparam int DIV_W = $clog2(TIMEBASE_HZ / RATE_1_HZ);
  localparam int TAP_1K = $clog2(TIMEBASE_HZ / RATE_1K_HZ) - 1;
  localparam int TAP_32 = $clog2(TIMEBASE_HZ / RATE_32_HZ) - 1;
  localparam int TAP_1 = $clog2(TIMEBASE_HZ / RATE_1_HZ) - 1;

endpackage : rtca_pkg

// ### hdl/rtca_div_if.sv
// Interface between the square-wave logic and its timebase divider.
`timescale 1ns/100ps
interface rtca_div_if;
  import rtca_pkg::*;
  logic tick;
  logic [DIV_W-1:0] count;
  modport div (input tick, output count);
  modport user (output tick, input count);
endinterface : rtca_div_if

// ### hdl/rtca_divider.sv
// Ripple-free binary divider of the 32.768 kHz timebase edges.
`timescale 1ns/100ps
module rtca_divider
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  rtca_div_if.div div
);
  import rtca_pkg::*;

  // ==========================================================================
  // Divider counter
  // ==========================================================================
  // Counting only timebase edges keeps every tap phase-locked to the timebase.
  // timebase division
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      div.count <= '0;
    end
    else if (div.tick)
    begin
      div.count <= div.count + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  AST_DIV_STEP: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    div.tick |=> div.count == $past(div.count) + {{(DIV_W-1){1'b0}}, 1'b1})
    else $error("Divider did not advance by one on a timebase edge.");

  AST_DIV_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!div.tick && $past(rst_n_i)) |=> div.count == $past(div.count))
    else $error("Divider moved without a timebase edge.");

endmodule : rtca_divider

// ### tb/rtca_host_model.sv
// Host model that drives the register strobe port and the outside gate pin.
`timescale 1ns/100ps
module rtca_host_model
(
  input wire logic clk_i,
  output logic [rtca_pkg::ADDR_W-1:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o,
  output logic gate_o
);
  import rtca_pkg::*;

  // ==========================================================================
  // Idle levels
  // ==========================================================================
  // Gate starts high so the output may run straight out of reset.
  initial
  begin
    reg_addr_o = 4'h0;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 8'h00;
    gate_o = 1'b1;
  end

  // ==========================================================================
  // Accesses
  // ==========================================================================
  // One strobe cycle per access. Released address and data lines show the inverse of their
  // last value, so a design that samples late cannot read stale data.
  task automatic access(input logic [3:0] addr, input logic [7:0] data, input logic wr);
    @(negedge clk_i);
    reg_addr_o = addr;
    reg_wdata_o = data;
    reg_wr_o = wr;
    reg_rd_o = ~wr;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = ~addr;
    reg_wdata_o = ~data;
  endtask : access

  task automatic set_gate(input logic level);
    @(negedge clk_i);
    gate_o = level;
  endtask : set_gate
endmodule : rtca_host_model

// ### tb/rtca_alarm_sqw_tb_top.sv
// Self-checking testbench of the alarm compare and square-wave block.
`timescale 1ns/100ps
module rtca_alarm_sqw_tb_top;
  import rtca_pkg::*;
  logic clk_i, rst_n_i, reg_wr, reg_rd, reg_rvalid, timebase, gate, sqw_pin, alarm;
  logic [ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [6:0] cur_min;
  logic [5:0] cur_hour, cur_date;
  logic [2:0] cur_wday;
  logic [7:0] exp_q[$];
  int bad_count = 0;
  int cmp_count = 0;
  logic [3:0] offs[5] = '{4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
  logic [7:0] masks[5] = '{8'hFF, 8'hBF, 8'hBF, 8'h87, 8'h83};
  logic [7:0] alv[4] = '{8'h15, 8'h23, 8'h31, 8'h06};
  logic [7:0] rnd;
  int tog, hi;

  // ==========================================================================
  // Instances and clocks
  // ==========================================================================
  rtca_host_model host (.clk_i(clk_i), .reg_addr_o(reg_addr), .reg_wr_o(reg_wr),
    .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata), .gate_o(gate));
  rtca_alarm_sqw dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid), .cur_minute_i(cur_min),
    .cur_hour_i(cur_hour), .cur_date_i(cur_date), .cur_weekday_i(cur_wday),
    .timebase_i(timebase), .square_wave_gate_pin_i(gate),
    .square_wave_pin_o(sqw_pin), .alarm_match_o(alarm));

  // 50 ns clock; the timebase runs fast (4 clocks) so slow rates fit the run.
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  initial
  begin
    timebase = 1'b0;
    forever
    begin
      repeat (2) @(negedge clk_i);
      timebase = ~timebase;
    end
  end

  // ==========================================================================
  // Checking
  // ==========================================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  // Each read answer is matched against the oldest noted expectation.
  always @(negedge clk_i)
  begin
    if (rst_n_i && reg_rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check(reg_rdata, 8'hEE);
      else
        check(reg_rdata, exp_q.pop_front());
    end
  end

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.access(a, 8'h00, 1'b0);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge clk_i);
    #1;
  endtask : settle

  // Counts timebase rises between the second and third output rise, which
  // skips any phase glitch left by a rate change.
  task automatic measure(input int exp_n);
    int n, seen;
    logic pp, pt;
    n = 0;
    seen = 0;
    pp = sqw_pin;
    pt = timebase;
    for (int i = 0; i < 20000 && seen < 3; i++)
    begin
      @(posedge clk_i);
      #1;
      if (timebase === 1'b1 && pt === 1'b0)
        n++;
      if (sqw_pin === 1'b1 && pp === 1'b0)
      begin
        seen++;
        if (seen == 2)
          n = 0;
      end
      pp = sqw_pin;
      pt = timebase;
    end
    // A pin that never rises three times counts as a failure and ends the run.
    if (seen < 3)
    begin
      bad_count++;
      final_report();
    end
    else
    begin
      check(n, exp_n);
    end
  endtask : measure

  task automatic quiet(input int cyc, output int t, output int h);
    logic pp;
    t = 0;
    h = 0;
    pp = sqw_pin;
    repeat (cyc)
    begin
      @(posedge clk_i);
      #1;
      if (sqw_pin !== pp)
        t++;
      if (sqw_pin !== 1'b0)
        h++;
      pp = sqw_pin;
    end
  endtask : quiet

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    rst_n_i = 1'b0;
    cur_min = 7'h15;
    cur_hour = 6'h23;
    cur_date = 6'h31;
    cur_wday = 3'h6;
    void'($urandom(32'h0100d5ed));
    repeat (5) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int i = 0; i < 5; i++)
      rd(offs[i], 8'h80);
    rd(4'h0, 8'h00);
    rd(4'hE, 8'h00);
    $display("test reset values done");
    measure(1);
    host.access(4'hD, 8'h83, 1'b1);
    repeat (8) @(negedge clk_i);
    quiet(3000, tog, hi);
    check(tog, 0);
    host.access(4'hD, 8'h81, 1'b1);
    measure(32);
    host.access(4'hD, 8'h82, 1'b1);
    measure(1024);
    host.access(4'hD, 8'h80, 1'b1);
    measure(1);
    host.access(4'hD, 8'h03, 1'b1);
    repeat (4) @(negedge clk_i);
    quiet(200, tog, hi);
    check(hi, 0);
    host.access(4'hD, 8'h80, 1'b1);
    host.set_gate(1'b0);
    repeat (4) @(negedge clk_i);
    quiet(200, tog, hi);
    check(hi, 0);
    host.set_gate(1'b1);
    measure(1);
    $display("test square wave done");
    for (int i = 0; i < 5; i++)
    begin
      for (int r = 0; r < 4; r++)
      begin
        rnd = (r == 0) ? 8'hFF : 8'($urandom);
        host.access(offs[i], rnd, 1'b1);
        rd(offs[i], rnd & masks[i]);
      end
    end
    host.access(4'h8, 8'hFF, 1'b1);
    rd(4'h8, 8'h00);
    $display("test register access done");
    for (int i = 0; i < 4; i++)
      host.access(offs[i], 8'h80, 1'b1);
    settle();
    check(alarm, 1'b0);
    for (int i = 0; i < 4; i++)
      host.access(offs[i], alv[i], 1'b1);
    settle();
    check(alarm, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      case (k)
        0: cur_min = 7'h16;
        1: cur_hour = 6'h22;
        2: cur_date = 6'h30;
        default: cur_wday = 3'h5;
      endcase
      settle();
      check(alarm, 1'b0);
      host.access(offs[k], alv[k] | 8'h80, 1'b1);
      settle();
      check(alarm, 1'b1);
      host.access(offs[k], alv[k], 1'b1);
      settle();
      check(alarm, 1'b0);
      cur_min = 7'h15;
      cur_hour = 6'h23;
      cur_date = 6'h31;
      cur_wday = 3'h6;
    end
    // Minute alone enabled must still match on its own.
    for (int i = 1; i < 4; i++)
      host.access(offs[i], alv[i] | 8'h80, 1'b1);
    settle();
    check(alarm, 1'b1);
    $display("test alarm done");
    repeat (4) @(negedge clk_i);
    check(exp_q.size(), 0);
    final_report();
  end

  // Guard against a hang anywhere in the sequence.
  initial
  begin
    repeat (90000) @(posedge clk_i);
    bad_count++;
    final_report();
  end
endmodule : rtca_alarm_sqw_tb_top
